// [hdl/bpm_parity.sv]
// Byte parity generator: odd parity per byte
module bpm_parity
  import bpm_pkg::*;
(
  input  wire logic [15:0] data,   // Word to cover
  output logic      [1:0]  par     // Bit 1 high byte, bit 0 low byte
);

  // Set when the byte has an even count of ones
  function automatic logic odd_bit(input logic [7:0] b);
    odd_bit = ~(^b);
  endfunction

  always_comb begin
    par[0] = odd_bit(data[7:0]);
    par[1] = odd_bit(data[15:8]);
  end

endmodule

// [hdl/bpm_pkg.sv]
// Package: constants and carriers of the byte-parity memory block
package bpm_pkg;

  // ****************************************
  // Widths and address map
  // ****************************************
  localparam int          BPM_WORD_W     = 16;
  localparam int          BPM_BYTE_W     = 8;
  localparam int          BPM_STORE_W    = 18;
  localparam int          BPM_BUS_AW     = 18;
  localparam int          BPM_VIRT_AW    = 16;
  localparam int          BPM_MEM_WORDS  = 16384;
  localparam int          BPM_IDX_W      = 14;
  localparam logic [17:0] BPM_MEM_TOP    = 18'o077776;
  localparam logic [17:0] BPM_IO_BASE    = 18'o760000;
  localparam logic [2:0]  BPM_IO_VPAGE   = 3'h7;
  localparam logic [1:0]  BPM_IO_HIGH    = 2'h3;
  localparam int          BPM_LOG_LO     = 9;
  localparam int          BPM_LOG_W      = 7;
  localparam int          BPM_CSR_EN_BIT = 0;
  localparam logic        BPM_CSR_EN_RST = 1'b0;
  localparam int          BPM_ACK_CYC    = 1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef enum logic [1:0] {
    BPM_RD_WORD,
    BPM_WR_WORD,
    BPM_WR_BYTE
  } bpm_op_t;

  typedef struct packed {
    logic        valid;
    bpm_op_t     op;
    logic        map_on;
    logic [15:0] vaddr;
    logic [17:0] reloc;
    logic [15:0] wdata;
  } bpm_req_t;

  typedef struct packed {
    logic        ack;
    logic        nxm;
    logic [15:0] rdata;
  } bpm_rsp_t;

endpackage

// [hdl/bpm_top.sv]
// Main memory with byte addressing, relocation and byte parity
module bpm_top
  import bpm_pkg::*;
#(
  parameter bit PARITY_FITTED = 1'b1  // Parity configuration present
)
(
  input  wire logic               clk,                    // 25 MHz clock
  input  wire logic               reset,                  // Synchronous, active high
  input  wire bpm_pkg::bpm_req_t  req,                    // Transfer request, same domain
  input  wire logic               err_enable,             // Error-enable bit level
  input  wire logic               log_clear,              // Clears indicator and log
  output bpm_pkg::bpm_rsp_t       rsp,                    // Transfer answer
  output logic                    bus_parity_error_line,  // Parity error to master
  output logic                    parity_led,             // Error indicator
  output logic [15:0]             csr_q_out               // Control register image
);
  import bpm_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  // No reset on the array: contents outlive reset, unwritten words read unknown
  logic [BPM_STORE_W-1:0] mem [BPM_MEM_WORDS];

  logic [17:0] baddr;
  logic [1:0]  wpar;
  logic [1:0]  rpar;
  logic [17:0] rword;

  bpm_xlate u_xlate (
    .map_on (req.map_on),
    .vaddr  (req.vaddr),
    .reloc  (req.reloc),
    .baddr  (baddr)
  );

  // Parity of incoming write data
  bpm_parity u_wpar (
    .data (req.wdata),
    .par  (wpar)
  );

  // ****************************************
  // Address decode
  // ****************************************
  logic hit;
  logic in_io;
  logic [BPM_IDX_W-1:0] idx;

  always_comb begin
    in_io = (baddr >= BPM_IO_BASE);
    hit   = !in_io && (baddr <= {BPM_MEM_TOP[17:1], 1'b1});
    idx   = baddr[BPM_IDX_W:1];
  end

  // ****************************************
  // Write path
  // ****************************************
  logic wr_en;
  logic [17:0] wr_word;
  logic [17:0] old_word;

  always_comb begin
    old_word = mem[idx];
    wr_en    = req.valid && hit && (req.op != BPM_RD_WORD);
    wr_word  = old_word;
    if (req.op == BPM_WR_WORD) begin
      wr_word = {wpar, req.wdata};
    end else if (baddr[0]) begin
      wr_word[15:8] = req.wdata[15:8];
      wr_word[17]   = wpar[1];
    end else begin
      wr_word[7:0]  = req.wdata[7:0];
      wr_word[16]   = wpar[0];
    end
    if (!PARITY_FITTED) begin
      wr_word[17:16] = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[idx] <= wr_word;
    end
  end

  // ****************************************
  // Read, check and log
  // ****************************************
  bpm_rsp_t    rsp_d;
  bpm_rsp_t    rsp_q;
  logic        perr_d;
  logic        perr_q;
  logic        led_d;
  logic        led_q;
  logic [15:0] csr_d;
  logic [15:0] csr_q;
  logic        rd_hit;

  bpm_parity u_rpar (
    .data (old_word[15:0]),
    .par  (rpar)
  );

  // Stored parity disagrees with the parity of the stored data
  function automatic logic word_bad(input logic [17:0] w, input logic [1:0] p);
    return p != w[17:16];
  endfunction

  always_comb begin
    rword   = old_word;
    rd_hit  = req.valid && hit && (req.op == BPM_RD_WORD);
    rsp_d   = '0;
    rsp_d.ack   = req.valid && hit;
    rsp_d.nxm   = req.valid && !hit;
    rsp_d.rdata = rd_hit ? rword[15:0] : 16'h0;
    perr_d  = 1'b0;
    led_d   = led_q;
    csr_d   = csr_q;
    csr_d[BPM_CSR_EN_BIT] = err_enable;
    if (log_clear) begin
      led_d = 1'b0;
      csr_d[BPM_LOG_LO +: BPM_LOG_W] = '0;
    end
    // Check only complete stored words against stored parity
    if (PARITY_FITTED && rd_hit && csr_q[BPM_CSR_EN_BIT]
        && word_bad(rword, rpar)) begin
      perr_d = 1'b1;
      led_d  = 1'b1;
      csr_d[BPM_LOG_LO +: BPM_LOG_W] = baddr[17:11];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_q  <= '0;
      perr_q <= 1'b0;
      led_q  <= 1'b0;
      csr_q  <= '0;
    end else begin
      rsp_q  <= rsp_d;
      perr_q <= perr_d;
      led_q  <= led_d;
      csr_q  <= csr_d;
    end
  end

  assign rsp                   = rsp_q;
  assign bus_parity_error_line = perr_q;
  assign parity_led            = led_q;
  assign csr_q_out             = csr_q;

  // ****************************************
  // Checks
  // ****************************************
  a_perr_needs_en: assert property (@(posedge clk) disable iff (reset)
    perr_q |-> $past(csr_q[BPM_CSR_EN_BIT])) else $error("parity error while checking disabled");
  a_led_follows_err: assert property (@(posedge clk) disable iff (reset)
    perr_q |-> led_q) else $error("indicator not lit on parity error");
  a_io_no_answer: assert property (@(posedge clk) disable iff (reset)
    (req.valid && in_io) |=> (!rsp_q.ack && rsp_q.nxm)) else $error("memory answered in peripheral page");
  a_map_off_reloc: assert property (@(posedge clk) disable iff (reset)
    (!req.map_on && req.vaddr[15:13] == 3'h7) |-> baddr[17:16] == 2'h3) else $error("top page not relocated");
  a_map_on_pass: assert property (@(posedge clk) disable iff (reset)
    req.map_on |-> baddr == req.reloc) else $error("mapped address altered");
  a_ack_hit: assert property (@(posedge clk) disable iff (reset)
    (req.valid && baddr <= BPM_MEM_TOP) |=> rsp_q.ack) else $error("in-range access not answered");
  a_log_addr: assert property (@(posedge clk) disable iff (reset)
    perr_q |-> csr_q[BPM_LOG_LO +: BPM_LOG_W] == $past(baddr[17:11])) else $error("error address not logged");
  a_wpar_odd: assert property (@(posedge clk) disable iff (reset)
    ^{wpar[0], req.wdata[7:0]} && ^{wpar[1], req.wdata[15:8]}) else $error("generated parity not odd");
  a_byte_keep: assert property (@(posedge clk) disable iff (reset)
    (wr_en && req.op == BPM_WR_BYTE && !baddr[0]) |-> wr_word[15:8] == old_word[15:8]
    && wr_word[17] == old_word[17]) else $error("byte write disturbed other byte");
  a_perr_pulse: assert property (@(posedge clk) disable iff (reset)
    (rd_hit && csr_q[0] && PARITY_FITTED && rpar != rword[17:16]) |=> perr_q) else $error("parity line not raised");

  // ****************************************
  // Checks: address map
  // ****************************************
  a_low_pass: assert property (@(posedge clk) disable iff (reset)
    (!req.map_on && req.vaddr[15:13] != BPM_IO_VPAGE) |-> baddr == {2'h0, req.vaddr})
    else $error("low virtual address altered");
  a_io_decode: assert property (@(posedge clk) disable iff (reset)
    (baddr >= BPM_IO_BASE) |-> (in_io && !hit))
    else $error("peripheral page taken as memory");
  a_top_in_io: assert property (@(posedge clk) disable iff (reset)
    (baddr[17:13] == 5'h1f) |-> in_io)
    else $error("top 4K words not reserved");
  a_above_mem: assert property (@(posedge clk) disable iff (reset)
    (baddr > {BPM_MEM_TOP[17:1], 1'b1}) |-> !hit)
    else $error("memory answered above its top");

  // ****************************************
  // Checks: write path
  // ****************************************
  a_word_both: assert property (@(posedge clk) disable iff (reset)
    (wr_en && req.op == BPM_WR_WORD) |-> wr_word[15:0] == req.wdata)
    else $error("word write dropped a byte");
  a_word_par: assert property (@(posedge clk) disable iff (reset)
    (wr_en && req.op == BPM_WR_WORD && PARITY_FITTED) |-> wr_word[17:16] == wpar)
    else $error("word parity not stored");
  a_byte_lo_new: assert property (@(posedge clk) disable iff (reset)
    (wr_en && req.op == BPM_WR_BYTE && !baddr[0]) |-> wr_word[7:0] == req.wdata[7:0])
    else $error("even byte address missed low byte");
  a_byte_hi_new: assert property (@(posedge clk) disable iff (reset)
    (wr_en && req.op == BPM_WR_BYTE && baddr[0]) |-> wr_word[15:8] == req.wdata[15:8])
    else $error("odd byte address missed high byte");
  a_byte_keep_lo: assert property (@(posedge clk) disable iff (reset)
    (wr_en && req.op == BPM_WR_BYTE && baddr[0]) |-> wr_word[7:0] == old_word[7:0]
    && wr_word[16] == old_word[16]) else $error("high byte write disturbed low byte");
  a_nxm_no_write: assert property (@(posedge clk) disable iff (reset)
    (req.valid && !hit) |-> !wr_en)
    else $error("write outside memory");
  a_read_no_write: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.op == BPM_RD_WORD) |-> !wr_en)
    else $error("read wrote memory");

  // ****************************************
  // Checks: read, report and log
  // ****************************************
  // Helper: word read at the last edge; a read must leave it as found
  logic                   rd_chk_q;
  logic [BPM_IDX_W-1:0]   rd_idx_q;
  logic [BPM_STORE_W-1:0] rd_word_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_chk_q  <= 1'b0;
      rd_idx_q  <= '0;
      rd_word_q <= '0;
    end else begin
      rd_chk_q  <= rd_hit;
      rd_idx_q  <= idx;
      rd_word_q <= old_word;
    end
  end

  a_read_keeps: assert property (@(posedge clk) disable iff (reset)
    rd_chk_q |-> mem[rd_idx_q] == rd_word_q)
    else $error("read altered stored word");
  // Answers are one-cycle pulses; a master holding valid gets one per cycle
  a_idle_quiet: assert property (@(posedge clk) disable iff (reset)
    !req.valid |=> (!rsp_q.ack && !rsp_q.nxm))
    else $error("answer without request");
  a_one_answer: assert property (@(posedge clk) disable iff (reset)
    !(rsp_q.ack && rsp_q.nxm))
    else $error("both answer and no-memory raised");
  a_wr_rdata_zero: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.op != BPM_RD_WORD) |=> rsp_q.rdata == 16'h0)
    else $error("data returned on a write");
  a_rd_data: assert property (@(posedge clk) disable iff (reset)
    rd_hit |=> rsp_q.rdata == $past(old_word[15:0]))
    else $error("read data not the stored word");
  a_en_copy: assert property (@(posedge clk) disable iff (reset)
    !reset |=> csr_q[BPM_CSR_EN_BIT] == $past(err_enable))
    else $error("error-enable bit not held");
  a_check_off: assert property (@(posedge clk) disable iff (reset)
    !csr_q[BPM_CSR_EN_BIT] |=> !perr_q)
    else $error("checked while disabled");
  a_perr_with_rd: assert property (@(posedge clk) disable iff (reset)
    perr_q |-> $past(rd_hit))
    else $error("parity error without a read");
  a_no_par_no_err: assert property (@(posedge clk) disable iff (reset)
    !PARITY_FITTED |-> !perr_q)
    else $error("parity error without parity fitted");
  a_perr_with_ack: assert property (@(posedge clk) disable iff (reset)
    perr_q |-> rsp_q.ack)
    else $error("parity line apart from its answer");
  a_led_sticky: assert property (@(posedge clk) disable iff (reset)
    (led_q && !log_clear) |=> led_q)
    else $error("indicator dropped without clear");
  a_clear_led: assert property (@(posedge clk) disable iff (reset)
    (log_clear && !perr_d) |=> !led_q)
    else $error("indicator not cleared");
  a_led_off: assert property (@(posedge clk) disable iff (reset)
    (!led_q && !perr_d) |=> !led_q)
    else $error("indicator lit without error");
  a_log_keep: assert property (@(posedge clk) disable iff (reset)
    (!perr_d && !log_clear) |=> csr_q[BPM_LOG_LO +: BPM_LOG_W] == $past(csr_q[BPM_LOG_LO +: BPM_LOG_W]))
    else $error("logged address changed");
  a_log_clear: assert property (@(posedge clk) disable iff (reset)
    (log_clear && !perr_d) |=> csr_q[BPM_LOG_LO +: BPM_LOG_W] == '0)
    else $error("logged address not cleared");

endmodule

// [hdl/bpm_xlate.sv]
// Address translator: virtual to 18-bit bus address
module bpm_xlate
  import bpm_pkg::*;
(
  input  wire logic        map_on,  // Memory management enabled
  input  wire logic [15:0] vaddr,   // Processor virtual address
  input  wire logic [17:0] reloc,   // Relocated address from mapping
  output logic      [17:0] baddr    // Bus address
);

  always_comb begin
    if (map_on) begin
      baddr = reloc;
    end else if (vaddr[15:13] == BPM_IO_VPAGE) begin
      baddr = {BPM_IO_HIGH, vaddr};
    end else begin
      baddr = {2'h0, vaddr};
    end
  end

endmodule

// [verif/bpm_mstr.sv]
// Bus master model: one transfer request at a time
module bpm_mstr
  import bpm_pkg::*;
(
  input  wire logic              clk,  // Bench clock
  output bpm_pkg::bpm_req_t      req,  // Request to memory
  input  wire bpm_pkg::bpm_rsp_t rsp   // Answer from memory
);
  timeunit 1ns;
  timeprecision 1ns;
  import bpm_pkg::*;
  initial req = '0;
  // Callers pass even virtual addresses on word ops
  task automatic xfer(input bpm_op_t op, input logic m, input logic [15:0] va,
                      input logic [17:0] rl, input logic [15:0] wd, output bpm_rsp_t r);
    @(posedge clk);
    req <= '{1'b1, op, m, va, rl, wd};
    @(posedge clk);
    // Released lines flip so stale values never look valid
    req <= '{1'b0, op, m, ~va, ~rl, ~wd};
    #1;
    r = rsp;
  endtask
endmodule

// [verif/tb_top.sv]
// Testbench: corner and random transfers against a shadow memory
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bpm_pkg::*;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; $display("Error %0t: mismatch", $time); end end
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        err_enable = 1'b0;
  logic        log_clear = 1'b0;
  bpm_req_t    req;
  bpm_rsp_t    rsp;
  bpm_rsp_t    r;
  logic        perr;
  logic        led;
  logic [15:0] csr;
  bpm_rsp_t    rsp_np;
  logic        perr_np;
  logic        led_np;
  logic [15:0] csr_np;
  logic [15:0] shadow [16384];
  logic [31:0] seed = 32'hae32;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  initial forever #20 clk = ~clk;
  bpm_mstr mst (.clk(clk), .req(req), .rsp(rsp));
  bpm_top dut (.clk(clk), .reset(reset), .req(req), .err_enable(err_enable), .log_clear(log_clear),
               .rsp(rsp), .bus_parity_error_line(perr), .parity_led(led), .csr_q_out(csr));
  // Same traffic into a build without parity: bus answers must not differ
  bpm_top #(.PARITY_FITTED(1'b0)) dut_np (.clk(clk), .reset(reset), .req(req), .err_enable(err_enable),
               .log_clear(log_clear), .rsp(rsp_np), .bus_parity_error_line(perr_np), .parity_led(led_np),
               .csr_q_out(csr_np));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Odd parity per byte, high byte's bit on top
  function automatic logic [1:0] par_of(input logic [15:0] w);
    return {~^w[15:8], ~^w[7:0]};
  endfunction
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d errors", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hangs end in the same closing report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ****************************************
  // Transfer with expectation
  // ****************************************
  task automatic go(input bpm_op_t op, input logic m, input logic [15:0] va, input logic [17:0] rl,
                    input logic [15:0] wd);
    logic [17:0] ba;
    logic        hit;
    logic [13:0] ix;
    ba = m ? rl : {{2{va[15:13] == 3'h7}}, va};
    hit = ba <= 18'o077777;
    ix = ba[14:1];
    mst.xfer(op, m, va, rl, wd, r);
    `CHK(r.ack, hit)
    `CHK(r.nxm, !hit)
    `CHK(perr, 1'b0)
    `CHK(led, 1'b0)
    `CHK(rsp_np, r)
    `CHK({perr_np, led_np}, 2'h0)
    if (hit && op == BPM_RD_WORD) `CHK(r.rdata, shadow[ix])
    if (hit && op == BPM_WR_WORD) shadow[ix] = wd;
    if (hit && op == BPM_WR_BYTE) shadow[ix] = ba[0] ? {wd[15:8], shadow[ix][7:0]} : {shadow[ix][15:8], wd[7:0]};
    if (hit && op != BPM_RD_WORD) begin
      `CHK(dut.mem[ix], {par_of(shadow[ix]), shadow[ix]})
      `CHK(dut_np.mem[ix], {2'h0, shadow[ix]})
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] v;
    logic [15:0] va;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK(csr, 16'h0000)
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      err_enable <= i[0];
      @(posedge clk);
      #1;
      `CHK(csr[0], i[0])
    end
    for (int i = 0; i < 32; i++) go(BPM_WR_WORD, 1'b0, 16'(i * 2), 18'h0, 16'(rnd()));
    $display("Test init done");
    go(BPM_WR_WORD, 1'b0, 16'o077776, 18'h0, 16'h5aa5);
    go(BPM_RD_WORD, 1'b0, 16'o077776, 18'h0, 16'h0);
    go(BPM_WR_WORD, 1'b0, 16'o100000, 18'h0, 16'h1234);
    go(BPM_WR_WORD, 1'b0, 16'o160000, 18'h0, 16'h1234);
    go(BPM_RD_WORD, 1'b0, 16'o177776, 18'h0, 16'h0);
    go(BPM_WR_WORD, 1'b1, 16'o160010, 18'o000010, 16'hc3c3);
    go(BPM_RD_WORD, 1'b1, 16'o000000, 18'o760000, 16'h0);
    go(BPM_WR_BYTE, 1'b0, 16'o000013, 18'h0, 16'hab00);
    go(BPM_WR_BYTE, 1'b0, 16'o000012, 18'h0, 16'h00cd);
    go(BPM_RD_WORD, 1'b0, 16'o000012, 18'h0, 16'h0);
    go(BPM_RD_WORD, 1'b1, 16'o000000, 18'o000010, 16'h0);
    $display("Test corners done");
    @(posedge clk);
    log_clear <= 1'b1;
    @(posedge clk);
    log_clear <= 1'b0;
    // Checking on: clean reads must never flag, so parity is generated right
    for (int i = 0; i < 300; i++) begin
      v = rnd();
      va = {10'h0, v[5:1], v[0] & (v[13:12] == 2'h2)};
      go(bpm_op_t'(v[13:12] % 3), v[14], va, v[9] ? {6'o76, v[27:16]} : {12'h0, va[5:0]}, v[31:16]);
    end
    `CHK(csr[BPM_LOG_LO +: BPM_LOG_W], 7'h00)
    `CHK(csr_np, csr)
    $display("Test random done");
    print_verdict();
  end
endmodule
